// File: verilog/cmoeg_top.sv
// output enable and mute gating for a two-input differential clock mux
// assumes pins arrive asynchronously; strap and config ports are ref_clk logic
// What this block does
// - outputs start only at an input clock rise and stop at one too, except on supply loss or auto loss mute, which clear at once
// - output runs only if pin, host and sideband enables all allow it
// - outputs muted unless input valid, power-good high and supply up
// - pending pin enable starts output cleanly once all conditions are met
// - after proper power-down both legs of every output go low cleanly
// - pin held inactive since power-up keeps its output muted until driven low
// - each input has a termination enable bit, reset to disabled
// - coupling bit: 0 is dc coupled, 1 is ac coupled with self bias
// - the two inputs have independent coupling and termination bits
// - pin, host and sideband enables all act at the same time in the eight- and sixteen-output variants
// - four-output variant: mode pin picks pin or host control
// - sideband clock up to 25 MHz; controller stays within it
// - host enables keep working while sideband control is in use
// - up to eight low-active pins; eight-output variant maps pin n to output n
// - sideband select high turns pins 3,4,6,7 into sideband signals
// - sixteen-output variant maps pin n to output 2n or 2n+1 by assignment
// - invalid input holds last level until loss flag, then auto mute to low
// - strobe high shifts on sideband clock rise; strobe fall loads enables
// - sideband load takes effect 4 to 10 input clock cycles after strobe fall
`timescale 1ns/100ps
`default_nettype none
module cmoeg_top (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic [1:0]                clk_in,
    input  wire logic                      clk_sel,
    input  wire logic                      input_loss_n,
    input  wire logic                      power_good_down_n,
    input  wire logic                      supply_ok,
    input  wire logic [7:0]                en_pin_n,
    input  wire logic                      host_mode_select,
    input  wire logic                      sideband_select,
    input  wire cmoeg_pkg::cmoeg_variant_e variant,
    input  wire logic [7:0]                pin_assign,
    input  wire logic [15:0]               host_out_en,
    input  wire logic                      auto_output_mute,
    input  wire logic                      cfg_wr,
    input  wire cmoeg_pkg::cmoeg_in_cfg_s  cfg_in,
    output logic [15:0]                    out_p,
    output logic [15:0]                    out_n,
    output logic                           sideband_data_out,
    output logic                           sideband_data_out_oe,
    output cmoeg_pkg::cmoeg_in_cfg_s       cfg_out
);

    localparam cmoeg_pkg::cmoeg_state_s ST_RST = '{
        pd_muted: 1'b1,
        sb_en:    cmoeg_pkg::SB_EN_RST,
        cfg:      '{term_en: cmoeg_pkg::CFG_RST, input_ac_couple_en: cmoeg_pkg::CFG_RST},
        default:  '0
    };

    cmoeg_pkg::cmoeg_state_s  st_reg;
    cmoeg_pkg::cmoeg_state_s  st_next;
    cmoeg_pkg::cmoeg_sb_load_s sb_load;
    logic                     sel_lvl;
    logic                     rise;
    logic                     valid;
    logic                     sb_active;
    logic                     host_only;
    logic [15:0]              pterm;
    logic [15:0]              hterm;
    logic [15:0]              want;

    function automatic logic is_sb_pin(input int n);
        return n == cmoeg_pkg::SB_CLK_PIN || n == cmoeg_pkg::SB_DIN_PIN ||
               n == cmoeg_pkg::SB_LD_PIN || n == cmoeg_pkg::SB_DOUT_PIN;
    endfunction

    function automatic logic [15:0] out_mask(input cmoeg_pkg::cmoeg_variant_e v);
        unique case (v)
            cmoeg_pkg::CMOEG_FOUR:    return cmoeg_pkg::OUT_MASK_FOUR;
            cmoeg_pkg::CMOEG_EIGHT:   return cmoeg_pkg::OUT_MASK_EIGHT;
            cmoeg_pkg::CMOEG_SIXTEEN: return cmoeg_pkg::OUT_MASK_SIXTEEN;
            default:                  return '0;
        endcase
    endfunction

    // pin enable term per output; outputs without a pin see an enable
    function automatic logic [15:0] pin_term(input cmoeg_pkg::cmoeg_variant_e v,
                                             input logic sb, input logic [7:0] asg,
                                             input logic [7:0] pn);
        logic [15:0] t;
        logic        on;
        t = '1;
        for (int n = 0; n < cmoeg_pkg::NUM_PIN; n++) begin
            on = ~pn[n] | (sb && is_sb_pin(n));
            unique case (v)
                cmoeg_pkg::CMOEG_FOUR: begin
                    if (n < 4) begin
                        t[n] = on;
                    end
                end
                cmoeg_pkg::CMOEG_EIGHT: begin
                    t[n] = on;
                end
                cmoeg_pkg::CMOEG_SIXTEEN: begin
                    t[2 * n + int'(asg[n])] = on;
                end
                default: begin
                    t = '0; // illegal variant code keeps every output off
                end
            endcase
        end
        return t;
    endfunction

    // four-output variant has no sideband port
    assign sb_active = st_reg.sbsel_s2 && variant != cmoeg_pkg::CMOEG_FOUR;
    assign host_only = variant == cmoeg_pkg::CMOEG_FOUR && st_reg.hm_s2;
    assign sel_lvl   = st_reg.clk_s2[st_reg.sel_s2];
    assign rise      = sel_lvl & ~st_reg.clk_prev;
    assign valid     = st_reg.los_s2;
    // four-output variant only: host mode ignores pins, pin mode ignores host bits
    assign pterm = host_only ? '1 : pin_term(variant, sb_active, pin_assign, st_reg.pin_s2);
    assign hterm = (variant == cmoeg_pkg::CMOEG_FOUR && !st_reg.hm_s2) ? '1 : host_out_en;

    cmoeg_sideband u_sideband (
        .ref_clk      (ref_clk),
        .rst_b        (rst_b),
        .active       (sb_active),
        .sck          (st_reg.pin_s2[cmoeg_pkg::SB_CLK_PIN]),
        .din          (st_reg.pin_s2[cmoeg_pkg::SB_DIN_PIN]),
        .shift_load_n (st_reg.pin_s2[cmoeg_pkg::SB_LD_PIN]),
        .load         (sb_load),
        .dout         (sideband_data_out)
    );

    always_comb begin
        st_next          = st_reg;
        // two-flop synchronisers on every asynchronous pin
        st_next.pin_s1   = en_pin_n;
        st_next.pin_s2   = st_reg.pin_s1;
        st_next.clk_s1   = clk_in;
        st_next.clk_s2   = st_reg.clk_s1;
        st_next.sel_s1   = clk_sel;
        st_next.sel_s2   = st_reg.sel_s1;
        st_next.los_s1   = input_loss_n;
        st_next.los_s2   = st_reg.los_s1;
        st_next.pd_s1    = power_good_down_n;
        st_next.pd_s2    = st_reg.pd_s1;
        st_next.sup_s1   = supply_ok;
        st_next.sup_s2   = st_reg.sup_s1;
        st_next.sbsel_s1 = sideband_select;
        st_next.sbsel_s2 = st_reg.sbsel_s1;
        st_next.hm_s1    = host_mode_select;
        st_next.hm_s2    = st_reg.hm_s1;
        st_next.clk_prev = sel_lvl;

        // power-down: mute only after enough input clock rises with pin low
        if (st_reg.pd_s2) begin
            st_next.pd_cnt   = '0;
            st_next.pd_muted = 1'b0;
        end else if (rise && st_reg.pd_cnt != cmoeg_pkg::PD_EDGES) begin
            st_next.pd_cnt = 2'(st_reg.pd_cnt + 2'h1);
            if (2'(st_reg.pd_cnt + 2'h1) == cmoeg_pkg::PD_EDGES) begin
                st_next.pd_muted = 1'b1;
            end
        end

        // sideband word waits a few input clock rises before it applies
        if (sb_load.valid) begin
            st_next.sb_pend = sb_load.data;
            st_next.sb_cnt  = cmoeg_pkg::SB_DELAY_MIN;
        end else if (rise && st_reg.sb_cnt != '0) begin
            st_next.sb_cnt = 4'(st_reg.sb_cnt - 4'h1);
            if (st_reg.sb_cnt == 4'h1) begin
                st_next.sb_en = st_reg.sb_pend;
            end
        end

        want = pterm & hterm & st_next.sb_en & out_mask(variant);
        if (!(valid && !st_next.pd_muted && st_reg.sup_s2)) begin
            want = '0;
        end

        // clock stopped or no supply: clearing at once is safe
        if (!st_reg.sup_s2 || (!valid && auto_output_mute)) begin
            st_next.gate = '0;
        end else if (rise) begin
            st_next.gate = want;
        end
        // a rise means p goes high with the gate, so no leg gets a short pulse
        st_next.out_p = st_next.gate & {16{sel_lvl}};
        st_next.out_n = st_next.gate & {16{~sel_lvl}};

        if (cfg_wr) begin
            st_next.cfg = cfg_in;
        end
        st_next.sb_oe = sb_active;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_p                = st_reg.out_p;
    assign out_n                = st_reg.out_n;
    assign sideband_data_out_oe = st_reg.sb_oe;
    assign cfg_out              = st_reg.cfg;

    a_gate_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ((st_reg.gate & ~$past(st_reg.gate)) != '0) |-> $past(rise))
        else $error("output started away from an input clock rise");

    a_and_of_terms: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rise && st_reg.sup_s2 && valid) |=> st_reg.gate == $past(want))
        else $error("gate does not match the and of enables");

    a_mute_no_supply: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !st_reg.sup_s2 |=> (st_reg.gate == '0 && st_reg.out_p == '0 && st_reg.out_n == '0))
        else $error("output runs without supply");

    a_loss_mutes_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!valid && auto_output_mute) |=> (st_reg.out_p == '0 && st_reg.out_n == '0))
        else $error("loss of input did not mute outputs");

    a_pd_mutes_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ($rose(st_reg.pd_muted) && st_reg.sup_s2) |-> (st_reg.gate == '0 && st_reg.out_p == '0))
        else $error("power-down did not mute outputs");

    a_sb_commit_word: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rise && st_reg.sb_cnt == 4'h1 && !sb_load.valid) |=> st_reg.sb_en == $past(st_reg.sb_pend))
        else $error("sideband word not applied after delay");

    a_sb_delay_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
        st_reg.sb_cnt <= cmoeg_pkg::SB_DELAY_MAX)
        else $error("sideband delay out of range");

    a_sb_pins_freed: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (sb_active && !host_only) |->
        ((variant == cmoeg_pkg::CMOEG_SIXTEEN) ?
         (pterm[{3'h3, pin_assign[3]}] && pterm[{3'h4, pin_assign[4]}] &&
          pterm[{3'h6, pin_assign[6]}] && pterm[{3'h7, pin_assign[7]}]) :
         (pterm[3] && pterm[4] && pterm[6] && pterm[7]))
        ##1 sideband_data_out_oe)
        else $error("sideband pins still act as enables");

    a_pin_map_eight: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (variant == cmoeg_pkg::CMOEG_EIGHT && !sb_active) |->
        (pterm[7:0] == ~st_reg.pin_s2 && pterm[15:8] == 8'hff))
        else $error("eight-output pin mapping wrong");

    a_pin_map_sixteen: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (variant == cmoeg_pkg::CMOEG_SIXTEEN) |->
        (pterm[{3'h0, pin_assign[0]}] == ~st_reg.pin_s2[0] && pterm[{3'h0, ~pin_assign[0]}]))
        else $error("sixteen-output pin mapping wrong");

    a_host_mode_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
        host_only |-> pterm == '1)
        else $error("pins act in host mode");

    a_cfg_reset_off: assert property (@(posedge ref_clk)
        !rst_b |=> cfg_out == '0)
        else $error("config bits not cleared by reset");

    a_legs_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_reg.out_p & st_reg.out_n) == '0)
        else $error("both legs of an output high");

    a_pin_high_mutes: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (variant == cmoeg_pkg::CMOEG_EIGHT && st_reg.pin_s2[0]) |-> !want[0])
        else $error("inactive pin lets its output run");

    a_hold_no_auto: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!valid && !auto_output_mute && st_reg.sup_s2 && !rise) |=>
        st_reg.gate == $past(st_reg.gate))
        else $error("gate moved while loss mute is off");

    a_sb_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_reg.sb_en != $past(st_reg.sb_en)) |-> $past(rise))
        else $error("sideband enables changed away from a rise");

    a_cfg_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_wr |=> cfg_out == $past(cfg_in))
        else $error("config write not taken");

    a_pd_no_run: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_reg.pd_muted && !st_reg.pd_s2) |-> want == '0)
        else $error("output wanted while powered down");

    a_pd_second_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rise && !st_reg.pd_s2 && st_reg.pd_cnt == 2'(cmoeg_pkg::PD_EDGES - 2'h1)) |=>
        st_reg.pd_muted)
        else $error("power-down not taken at second rise");

    a_host_term: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (variant != cmoeg_pkg::CMOEG_FOUR) |-> hterm == host_out_en)
        else $error("host enables ignored");

    c_out_start: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(st_reg.gate[0]));
    c_pd_mute: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(st_reg.pd_muted));
    c_sb_apply: cover property (@(posedge ref_clk) disable iff (!rst_b)
        rise && st_reg.sb_cnt == 4'h1);

endmodule
`default_nettype wire

// File: verilog/cmoeg_pkg.sv
// shared constants and types for the clock mux output enable gating block
// assumes one ref_clk domain; every pin-facing input is synchronised inside cmoeg_top
package cmoeg_pkg;

    localparam int NUM_OUT = 16;
    localparam int NUM_PIN = 8;

    // enable pins that double as sideband pins
    localparam int SB_CLK_PIN  = 3;
    localparam int SB_DIN_PIN  = 4;
    localparam int SB_LD_PIN   = 6;
    localparam int SB_DOUT_PIN = 7;

    // output count masks per variant
    localparam logic [15:0] OUT_MASK_FOUR    = 16'h000f;
    localparam logic [15:0] OUT_MASK_EIGHT   = 16'h00ff;
    localparam logic [15:0] OUT_MASK_SIXTEEN = 16'hffff;

    // input clock rising edges with power-down low before muting
    localparam logic [1:0] PD_EDGES = 2'h2;

    // sideband load to output effect, in input clock cycles
    localparam logic [3:0] SB_DELAY_MIN = 4'h4;
    localparam logic [3:0] SB_DELAY_MAX = 4'ha;

    // sideband clock limit, and ref_clk period, both in ns
    localparam int SB_MIN_PERIOD_NS = 40;
    localparam int REF_PERIOD_NS    = 100;

    // reset values and coupling bit codes
    localparam logic [15:0] SB_EN_RST  = 16'hffff;
    localparam logic [1:0]  CFG_RST    = 2'h0;
    localparam logic        COUPLE_DC  = 1'h0;
    localparam logic        COUPLE_AC  = 1'h1;

    typedef enum logic [1:0] {
        CMOEG_FOUR,
        CMOEG_EIGHT,
        CMOEG_SIXTEEN
    } cmoeg_variant_e;

    // per-input configuration, index = clock input
    typedef struct packed {
        logic [1:0] term_en;
        logic [1:0] input_ac_couple_en;
    } cmoeg_in_cfg_s;

    // sideband load event with the shifted word
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } cmoeg_sb_load_s;

    typedef struct packed {
        logic           sck_prev;
        logic           ld_prev;
        logic [15:0]    sr;
        cmoeg_sb_load_s load;
        logic           dout;
    } cmoeg_sb_state_s;

    typedef struct packed {
        logic [7:0]    pin_s1;
        logic [7:0]    pin_s2;
        logic [1:0]    clk_s1;
        logic [1:0]    clk_s2;
        logic          clk_prev;
        logic          sel_s1;
        logic          sel_s2;
        logic          los_s1;
        logic          los_s2;
        logic          pd_s1;
        logic          pd_s2;
        logic          sup_s1;
        logic          sup_s2;
        logic          sbsel_s1;
        logic          sbsel_s2;
        logic          hm_s1;
        logic          hm_s2;
        logic [1:0]    pd_cnt;
        logic          pd_muted;
        logic [15:0]   gate;
        logic [15:0]   out_p;
        logic [15:0]   out_n;
        logic [15:0]   sb_en;
        logic [15:0]   sb_pend;
        logic [3:0]    sb_cnt;
        cmoeg_in_cfg_s cfg;
        logic          sb_oe;
    } cmoeg_state_s;

endpackage

// File: verilog/cmoeg_sideband.sv
// sideband serial shifter: shift on sideband clock rise, load on strobe fall
// assumes inputs are already synchronised to ref_clk by the caller
`timescale 1ns/100ps
`default_nettype none
module cmoeg_sideband (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    input  wire logic                      active,
    input  wire logic                      sck,
    input  wire logic                      din,
    input  wire logic                      shift_load_n,
    output cmoeg_pkg::cmoeg_sb_load_s      load,
    output logic                           dout
);

    cmoeg_pkg::cmoeg_sb_state_s st_reg;
    cmoeg_pkg::cmoeg_sb_state_s st_next;
    logic                       sck_rise;

    // sampled sideband clock, so its rate is bounded by ref_clk
    assign sck_rise = active & sck & ~st_reg.sck_prev;

    always_comb begin
        st_next            = st_reg;
        st_next.sck_prev   = sck;
        st_next.ld_prev    = shift_load_n;
        st_next.load.valid = 1'b0;
        if (sck_rise && shift_load_n) begin
            st_next.sr   = {st_reg.sr[14:0], din};
            st_next.dout = st_reg.sr[15];
        end
        if (active && st_reg.ld_prev && !shift_load_n) begin
            st_next.load.valid = 1'b1;
            st_next.load.data  = st_reg.sr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign load = st_reg.load;
    assign dout = st_reg.dout;

    a_shift_in_data: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (sck_rise && shift_load_n) |=> st_reg.sr == {$past(st_reg.sr[14:0]), $past(din)})
        else $error("sideband shift did not take data in");

    a_load_on_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (active && $fell(shift_load_n)) |=> (load.valid && load.data == $past(st_reg.sr)))
        else $error("sideband load missed strobe fall");

    c_sb_load: cover property (@(posedge ref_clk) disable iff (!rst_b) load.valid);

endmodule
`default_nettype wire

// File: tb/cmoeg_board_model.sv
// board controller model: drives the enable pins and the sideband pins
// assumes the bench clocks it with ref_clk and sets the plain pin requests
`timescale 1ns/100ps
`default_nettype none
module cmoeg_board_model (
    input  wire logic       ref_clk,
    input  wire logic       sb_mode,
    input  wire logic [7:0] pin_req,
    output logic [7:0]      en_pin_n
);
    logic sck;
    logic din;
    logic ld_n;

    initial begin
        sck  = 1'b0;
        din  = 1'b0;
        ld_n = 1'b1;
    end

    // sideband pins take over pins 3, 4 and 6 only in sideband mode
    always_comb begin
        en_pin_n = pin_req;
        if (sb_mode) begin
            en_pin_n[3] = sck;
            en_pin_n[4] = din;
            en_pin_n[6] = ld_n;
        end
    end

    // msb first, so the first bit lands in bit 15; strobe idles high
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            sck <= 1'b0;
            din <= w[i];
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        sck <= 1'b0; // clock stands still outside frames
        din <= ~w[0]; // hold time over, no stale bit left on the line
        repeat (4) @(posedge ref_clk);
        ld_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ld_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: tb/test_cmoeg_top.sv
// self-checking bench for the output enable gating block
// assumes the board model on the pins and free running input clocks
`timescale 1ns/100ps
`default_nettype none
module test_cmoeg_top;
    logic                      ref_clk = 1'b0;
    logic                      rst_b;
    logic [1:0]                clk_in;
    logic                      clk_sel;
    logic                      input_loss_n;
    logic                      power_good_down_n;
    logic                      supply_ok;
    logic [7:0]                pin_req;
    logic [7:0]                en_pin_n;
    logic                      host_mode_select;
    logic                      sideband_select;
    cmoeg_pkg::cmoeg_variant_e variant;
    logic [7:0]                pin_assign;
    logic [15:0]               host_out_en;
    logic                      auto_output_mute;
    logic                      cfg_wr;
    cmoeg_pkg::cmoeg_in_cfg_s  cfg_in;
    cmoeg_pkg::cmoeg_in_cfg_s  cfg_out;
    logic [15:0]               out_p;
    logic [15:0]               out_n;
    logic                      sideband_data_out;
    logic                      sideband_data_out_oe;
    logic [15:0]               sb_word;
    logic [7:0]                div = 8'h0;
    int                        n_mismatch = 0;
    int                        checks_done = 0;
    int                        cyc = 0;

    always #50 ref_clk = ~ref_clk;

    // input clocks of 4 and 8 ref cycles, both always running
    always @(posedge ref_clk) begin
        div    <= div + 8'h1;
        clk_in <= {div[2], div[1]};
    end

    cmoeg_board_model i_cmoeg_board_model (
        .ref_clk (ref_clk),
        .sb_mode (sideband_select),
        .pin_req (pin_req),
        .en_pin_n(en_pin_n)
    );

    cmoeg_top i_cmoeg_top (
        .ref_clk             (ref_clk),
        .rst_b               (rst_b),
        .clk_in              (clk_in),
        .clk_sel             (clk_sel),
        .input_loss_n        (input_loss_n),
        .power_good_down_n   (power_good_down_n),
        .supply_ok           (supply_ok),
        .en_pin_n            (en_pin_n),
        .host_mode_select    (host_mode_select),
        .sideband_select     (sideband_select),
        .variant             (variant),
        .pin_assign          (pin_assign),
        .host_out_en         (host_out_en),
        .auto_output_mute    (auto_output_mute),
        .cfg_wr              (cfg_wr),
        .cfg_in              (cfg_in),
        .out_p               (out_p),
        .out_n               (out_n),
        .sideband_data_out   (sideband_data_out),
        .sideband_data_out_oe(sideband_data_out_oe),
        .cfg_out             (cfg_out)
    );

    task automatic end_of_test();
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
        checks_done++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // effective enables from the current pin, host and sideband terms
    function automatic logic [15:0] expected();
        logic [15:0] pt;
        logic [15:0] hs;
        logic [15:0] sw;
        logic [15:0] m;
        logic        sbx;
        pt  = 16'hffff;
        hs  = host_out_en;
        sw  = sb_word;
        m   = cmoeg_pkg::OUT_MASK_EIGHT;
        sbx = sideband_select && (variant != cmoeg_pkg::CMOEG_FOUR);
        for (int n = 0; n < 8; n++) begin
            if (!(sbx && (n == 3 || n == 4 || n == 6 || n == 7))) begin
                if (variant == cmoeg_pkg::CMOEG_SIXTEEN) begin
                    pt[2 * n + int'(pin_assign[n])] = ~pin_req[n];
                end else begin
                    pt[n] = ~pin_req[n];
                end
            end
        end
        if (variant == cmoeg_pkg::CMOEG_SIXTEEN) begin
            m = cmoeg_pkg::OUT_MASK_SIXTEEN;
        end
        if (variant == cmoeg_pkg::CMOEG_FOUR) begin
            m  = cmoeg_pkg::OUT_MASK_FOUR;
            sw = 16'hffff;
            if (host_mode_select) begin
                pt = 16'hffff;
            end else begin
                hs = 16'hffff;
            end
        end
        // running input with loss flagged mutes at the next rise whatever the auto mute
        if (!supply_ok || !power_good_down_n || !input_loss_n) begin
            m = 16'h0;
        end
        return pt & hs & sw & m;
    endfunction

    // 30 cycles covers sync, the slowest input period and the output flop
    task automatic settle_check(input string what);
        repeat (30) @(posedge ref_clk);
        check(what, out_p | out_n, expected());
        check("leg overlap", out_p & out_n, 16'h0);
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        logic [15:0] w;
        logic [3:0]  c;
        void'($urandom(37529));
        rst_b = 1'b0;
        clk_sel = 1'b0;
        input_loss_n = 1'b1;
        power_good_down_n = 1'b1;
        supply_ok = 1'b1;
        pin_req = 8'hff;
        host_mode_select = 1'b0;
        sideband_select = 1'b0;
        variant = cmoeg_pkg::CMOEG_EIGHT;
        pin_assign = 8'h0;
        host_out_en = 16'hffff;
        auto_output_mute = 1'b1;
        cfg_wr = 1'b0;
        cfg_in = '0;
        sb_word = cmoeg_pkg::SB_EN_RST;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        settle_check("muted while pins high");
        check("cfg after reset", {12'h0, cfg_out},
              {12'h0, cmoeg_pkg::CFG_RST, cmoeg_pkg::CFG_RST});
        for (int i = 0; i < 4; i++) begin
            c = 4'($urandom);
            @(posedge ref_clk);
            cfg_in <= c;
            cfg_wr <= 1'b1;
            @(posedge ref_clk);
            cfg_in <= ~c;
            cfg_wr <= 1'b0;
            @(posedge ref_clk);
            check("input config", {12'h0, cfg_out}, {12'h0, c});
        end
        for (int i = 0; i < 15; i++) begin
            @(posedge ref_clk);
            variant <= cmoeg_pkg::cmoeg_variant_e'(i % 3);
            pin_req <= 8'($urandom);
            host_out_en <= 16'($urandom);
            pin_assign <= 8'($urandom);
            host_mode_select <= 1'($urandom);
            clk_sel <= 1'($urandom);
            settle_check("gated outputs");
        end
        @(posedge ref_clk);
        variant <= cmoeg_pkg::CMOEG_EIGHT;
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            input_loss_n <= (k != 0) && (k != 3);
            supply_ok <= (k != 1);
            power_good_down_n <= (k != 2);
            auto_output_mute <= (k != 3);
            settle_check("muting condition");
            if (k != 3) begin
                @(posedge ref_clk);
                pin_req <= 8'($urandom);
                settle_check("pins moved while muted");
            end
            @(posedge ref_clk);
            input_loss_n <= 1'b1;
            supply_ok <= 1'b1;
            power_good_down_n <= 1'b1;
            auto_output_mute <= 1'b1;
            settle_check("restart after muting");
        end
        @(posedge ref_clk);
        pin_req <= 8'h40;
        host_out_en <= 16'hffff;
        clk_sel <= 1'b0;
        sideband_select <= 1'b1;
        settle_check("pins remapped to sideband");
        check("data out enable", {15'h0, sideband_data_out_oe}, 16'h1);
        w = 16'($urandom) & 16'hfffe;
        @(posedge ref_clk);
        i_cmoeg_board_model.send_word(w);
        repeat (6) @(posedge ref_clk);
        check("before load applies", out_p | out_n, expected());
        // first word pushes out the cleared reset contents
        check("serial out", {15'h0, sideband_data_out}, 16'h0);
        sb_word = w;
        repeat (34) @(posedge ref_clk);
        check("after load applies", out_p | out_n, expected());
        @(posedge ref_clk);
        host_out_en <= 16'($urandom);
        settle_check("host enables beside sideband");
        end_of_test();
    end
endmodule
`default_nettype wire
